// ===== src/xmc_defs.vh
// constants, offsets and memory map of the module management block
// Overview of operation
// - answer the management link only while the select input is held low
// - pull the active-low interrupt output low on an important condition
// - transmitter-off high switches the laser off; low enables it unless the control laser-off bit is set
// - signal-lost output is 0 in normal reception, 1 on loss of signal
// - module-absent output is held low permanently
// - module-fault output is asserted on an operational fault
// - power-down input high enters low-power mode
// - management link keeps working fully in low-power mode
// - falling edge of power-down/reset performs a complete reset
// - data bits captured on rising clock, stored only in unprotected memory
// - read data bits are shifted out on the falling clock edge
// - memory is byte-wide, bytes addressed singly or in a run
// - random and sequential access from address zero to the top address
// - live temperature, bias, tx power, rx power, supply in memory
// - alarm and warning flags set when a value leaves its range
`ifndef XMC_DEFS_VH
`define XMC_DEFS_VH
`define XMC_DEV_ADDR 7'h50
`define XMC_WP_END 8'h10
`define XMC_REG_STATUS 4'h0
`define XMC_REG_MASK 4'h1
`define XMC_REG_CTRL 4'h2
`define XMC_REG_STATE 4'h3
`define XMC_CTRL_FAULT 0
`define XMC_CTRL_LASER_OFF 1
`define XMC_EV_ALARM 0
`define XMC_EV_WARN 1
`define XMC_EV_LOS 2
`define XMC_EV_FAULT 3
`define XMC_MAP_LIVE 8'h00
`define XMC_MAP_ALARM_HI 8'h05
`define XMC_MAP_ALARM_LO 8'h06
`define XMC_MAP_WARN_HI 8'h07
`define XMC_MAP_WARN_LO 8'h08
`define XMC_MAP_PINS 8'h09
`define XMC_MAP_THR 8'h10
`define XMC_NUM_MON 5
`define XMC_STATUS_RST 4'h0
`define XMC_MASK_RST 4'h0
`define XMC_CTRL_RST 2'h0
`endif

// ===== src/xmc_mgmt_control.v
// management serial slave, diagnostics memory and status pins
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ns
`include "xmc_defs.vh"
module xmc_mgmt_control #(
    parameter DEPTH = 256,
    parameter [6:0] DEV_ADDR = `XMC_DEV_ADDR,
    parameter [7:0] WP_END = `XMC_WP_END
)(
    input wire clk,
    input wire rst_b,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire mod_desel_b,
    input wire transmitter_off,
    input wire power_down_reset,
    input wire los_detect,
    input wire fault_detect,
    input wire [7:0] mon_temp,
    input wire [7:0] mon_bias,
    input wire [7:0] mon_txpow,
    input wire [7:0] mon_rxpow,
    input wire [7:0] mon_vcc,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg interrupt_b,
    output reg receive_signal_lost,
    output reg module_fault,
    output reg module_absent,
    output reg laser_enable,
    output reg low_power_mode
);
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_AACK = 7'h04;
    localparam [6:0] ST_WR = 7'h08;
    localparam [6:0] ST_WACK = 7'h10;
    localparam [6:0] ST_RD = 7'h20;
    localparam [6:0] ST_RACK = 7'h40;
    localparam [31:0] TOPI = DEPTH - 1;
    localparam [7:0] TOP = TOPI[7:0];

    // synchroniser stages: scl, sda, desel, txoff, pd, los, fault
    reg [6:0] syn1;
    reg [6:0] syn2;
    reg scl_p;
    reg sda_p;
    reg pd_p;
    wire scl_r = syn2[0];
    wire sda_r = syn2[1];
    wire sel = ~syn2[2];
    wire txoff_r = syn2[3];
    wire pd_r = syn2[4];
    wire los_r = syn2[5];
    wire fault_r = syn2[6];

    reg [7:0] mem [0:DEPTH-1];
    reg [6:0] state;
    reg [3:0] cnt;
    reg [7:0] sh;
    reg [7:0] ptr;
    reg rw;
    reg first;
    reg nack;
    reg [4:0] alarm_hi;
    reg [4:0] alarm_lo;
    reg [4:0] warn_hi;
    reg [4:0] warn_lo;
    reg [3:0] status;
    reg [3:0] mask;
    reg [1:0] ctrl;
    reg [3:0] next_status;
    reg [7:0] byte_out;
    reg [7:0] byte_ahead;
    integer i;
    integer j;

    wire [39:0] mon_bus = {mon_vcc, mon_rxpow, mon_txpow, mon_bias, mon_temp};
    wire scl_rise = scl_r & ~scl_p;
    wire scl_fall = ~scl_r & scl_p;
    wire start_c = scl_r & scl_p & sda_p & ~sda_r;
    wire stop_c = scl_r & scl_p & ~sda_p & sda_r;
    wire pd_fall = pd_p & ~pd_r;
    wire full_rst = ~rst_b | pd_fall;
    wire [3:0] events;

    // next address of a run, held at the top
    function [7:0] inc_ptr;
        input [7:0] p;
        begin
            inc_ptr = (p == TOP) ? p : p + 8'h01;
        end
    endfunction

    // byte seen by the host at an address
    function [7:0] map_byte;
        input [7:0] a;
        begin
            if (a < `XMC_NUM_MON)
                map_byte = mon_bus[a*8 +: 8];
            else if (a == `XMC_MAP_ALARM_HI)
                map_byte = {3'h0, alarm_hi};
            else if (a == `XMC_MAP_ALARM_LO)
                map_byte = {3'h0, alarm_lo};
            else if (a == `XMC_MAP_WARN_HI)
                map_byte = {3'h0, warn_hi};
            else if (a == `XMC_MAP_WARN_LO)
                map_byte = {3'h0, warn_lo};
            else if (a == `XMC_MAP_PINS)
                map_byte = {3'h0, pd_r, fault_r, los_r, txoff_r, sel};
            else if (a < WP_END)
                map_byte = 8'h00;
            else
                map_byte = mem[a];
        end
    endfunction

    assign events = {fault_r | ctrl[`XMC_CTRL_FAULT], los_r,
        |(warn_hi | warn_lo), |(alarm_hi | alarm_lo)};

    // input synchronisers, reset only by the reset pin
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            syn1 <= 7'h07;
            syn2 <= 7'h07;
            pd_p <= 1'b0;
        end
        else
        begin
            syn1 <= {fault_detect, los_detect, power_down_reset, transmitter_off,
                mod_desel_b, sda_in, scl_in};
            syn2 <= syn1;
            pd_p <= pd_r;
        end
    end

    // serial slave: capture on rise, drive on fall
    always @(posedge clk)
    begin
        if (full_rst)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            first <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= 8'h00;
        end
        else
        begin
            scl_p <= scl_r;
            sda_p <= sda_r;
            if (!sel)
            begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else if (start_c)
            begin
                state <= ST_ADDR;
                cnt <= 4'h0;
                first <= 1'b1;
                sda_oe <= 1'b0;
            end
            else if (stop_c)
            begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            sh <= {sh[6:0], sda_r};
                            cnt <= cnt + 4'h1;
                        end
                        else if (scl_fall && cnt == 4'h8)
                        begin
                            if (sh[7:1] == DEV_ADDR)
                            begin
                                state <= ST_AACK;
                                rw <= sh[0];
                                sda_oe <= 1'b1;
                            end
                            else
                                state <= ST_IDLE;
                        end
                    end
                    ST_AACK:
                    begin
                        if (scl_fall)
                        begin
                            cnt <= 4'h0;
                            if (rw)
                            begin
                                state <= ST_RD;
                                sh <= byte_out;
                                sda_oe <= ~byte_out[7];
                            end
                            else
                            begin
                                state <= ST_WR;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    ST_WR:
                    begin
                        if (scl_rise)
                        begin
                            sh <= {sh[6:0], sda_r};
                            cnt <= cnt + 4'h1;
                        end
                        else if (scl_fall && cnt == 4'h8)
                        begin
                            state <= ST_WACK;
                            sda_oe <= 1'b1;
                            if (first)
                            begin
                                ptr <= sh;
                                first <= 1'b0;
                            end
                            else
                            begin
                                if (ptr >= WP_END && ptr <= TOP)
                                    mem[ptr] <= sh;
                                ptr <= inc_ptr(ptr);
                            end
                        end
                    end
                    ST_WACK:
                    begin
                        if (scl_fall)
                        begin
                            state <= ST_WR;
                            cnt <= 4'h0;
                            sda_oe <= 1'b0;
                        end
                    end
                    ST_RD:
                    begin
                        if (scl_rise)
                            cnt <= cnt + 4'h1;
                        else if (scl_fall)
                        begin
                            if (cnt == 4'h8)
                            begin
                                state <= ST_RACK;
                                sda_oe <= 1'b0;
                            end
                            else
                            begin
                                sh <= {sh[6:0], 1'b0};
                                sda_oe <= ~sh[6];
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_rise)
                            nack <= sda_r;
                        else if (scl_fall)
                        begin
                            ptr <= inc_ptr(ptr);
                            cnt <= 4'h0;
                            if (nack)
                            begin
                                state <= ST_IDLE;
                                sda_oe <= 1'b0;
                            end
                            else
                            begin
                                state <= ST_RD;
                                sh <= byte_ahead;
                                sda_oe <= ~byte_ahead[7];
                            end
                        end
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // read bytes looked up a clock ahead
    always @(posedge clk)
    begin
        byte_out <= map_byte(ptr);
        byte_ahead <= map_byte(inc_ptr(ptr));
    end

    // range checks against thresholds in memory
    always @(posedge clk)
    begin
        if (full_rst)
        begin
            alarm_hi <= 5'h00;
            alarm_lo <= 5'h00;
            warn_hi <= 5'h00;
            warn_lo <= 5'h00;
        end
        else
        begin
            for (j = 0; j < `XMC_NUM_MON; j = j + 1)
            begin
                alarm_hi[j] <= mon_bus[j*8 +: 8] > mem[`XMC_MAP_THR + 4*j];
                alarm_lo[j] <= mon_bus[j*8 +: 8] < mem[`XMC_MAP_THR + 4*j + 1];
                warn_hi[j] <= mon_bus[j*8 +: 8] > mem[`XMC_MAP_THR + 4*j + 2];
                warn_lo[j] <= mon_bus[j*8 +: 8] < mem[`XMC_MAP_THR + 4*j + 3];
            end
        end
    end

    // sticky status, write one to clear, set wins
    always @*
    begin
        next_status = status;
        if (reg_wr && reg_addr == `XMC_REG_STATUS)
            next_status = status & ~reg_wdata[3:0];
        next_status = next_status | events;
    end

    // register port and pin outputs
    always @(posedge clk)
    begin
        if (full_rst)
        begin
            status <= `XMC_STATUS_RST;
            mask <= `XMC_MASK_RST;
            ctrl <= `XMC_CTRL_RST;
            reg_rdata <= 8'h00;
            interrupt_b <= 1'b1;
            receive_signal_lost <= 1'b0;
            module_fault <= 1'b0;
            module_absent <= 1'b0;
            laser_enable <= 1'b0;
            low_power_mode <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            status <= next_status;
            if (reg_wr && reg_addr == `XMC_REG_MASK)
                mask <= reg_wdata[3:0];
            if (reg_wr && reg_addr == `XMC_REG_CTRL)
                ctrl <= reg_wdata[1:0];
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `XMC_REG_STATUS: reg_rdata <= {4'h0, status};
                    `XMC_REG_MASK: reg_rdata <= {4'h0, mask};
                    `XMC_REG_CTRL: reg_rdata <= {6'h00, ctrl};
                    `XMC_REG_STATE: reg_rdata <= {1'b0, state};
                    default: reg_rdata <= 8'h00;
                endcase
            end
            interrupt_b <= ~|(next_status & mask);
            receive_signal_lost <= los_r;
            module_fault <= fault_r | ctrl[`XMC_CTRL_FAULT];
            module_absent <= 1'b0;
            laser_enable <= ~txoff_r & ~ctrl[`XMC_CTRL_LASER_OFF];
            low_power_mode <= pd_r;
            sda_out <= 1'b0;
        end
    end
    // the serial slave above never looks at low_power_mode
endmodule // xmc_mgmt_control

// ===== sim/xmc_assertions.sv
// concurrent checks on the management block pins
`timescale 1ns/1ns
module xmc_assertions (
    input wire clk,
    input wire rst_b,
    input wire scl_in,
    input wire sda_oe,
    input wire mod_desel_b,
    input wire transmitter_off,
    input wire power_down_reset,
    input wire los_detect,
    input wire fault_detect,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire interrupt_b,
    input wire receive_signal_lost,
    input wire module_fault,
    input wire module_absent,
    input wire laser_enable,
    input wire low_power_mode
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!rst_b);
sequence s_pd_fall;
    $fell(power_down_reset) ##1 !power_down_reset [*7];
endsequence
sequence s_mask_off;
    reg_wr && reg_addr == 4'h1 && reg_wdata == 8'h00;
endsequence
AST_DESEL: assert property (mod_desel_b [*4] |=> !sda_oe)
    else $error("data line driven while deselected");
AST_IRQ_MASK: assert property (s_mask_off |-> ##[1:3] interrupt_b)
    else $error("interrupt stays low with mask cleared");
AST_LASER: assert property (transmitter_off [*4] |=> !laser_enable)
    else $error("laser on while transmitter off");
AST_LOS: assert property (los_detect [*4] |=> receive_signal_lost)
    else $error("signal lost not shown");
AST_ABSENT: assert property (!module_absent)
    else $error("module absent high");
AST_FAULT: assert property (fault_detect [*4] |=> module_fault)
    else $error("fault not shown");
AST_LOWPWR: assert property (power_down_reset [*4] |=> low_power_mode)
    else $error("low power mode not entered");
AST_PD_RESET: assert property (s_pd_fall |-> interrupt_b && !sda_oe)
    else $error("state kept after power-down fall");
AST_SDA_EDGE: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data line driven while clock high");
endmodule // xmc_assertions

// ===== sim/xmc_host_model.sv
// host-side controller model: serial clock and framing
`timescale 1ns/1ns
module xmc_host_model (
    output reg scl,
    output reg sda_low,
    input wire sda
);
initial
begin
    scl = 1'b1;
    sda_low = 1'b0;
end
task clk_bit(input logic b, output logic r);
begin
    sda_low = !b;
    #31;
    scl = 1'b1;
    #63;
    r = sda;
    scl = 1'b0;
    #31;
end
endtask
task start;
begin
    sda_low = 1'b0;
    #31;
    scl = 1'b1;
    #31;
    sda_low = 1'b1;
    #31;
    scl = 1'b0;
    #31;
end
endtask
task stop;
begin
    sda_low = 1'b1;
    #31;
    scl = 1'b1;
    #31;
    sda_low = 1'b0;
    #63;
end
endtask
task xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    integer i;
begin
    for (i = 7; i >= 0; i--)
        clk_bit(tx[i], rx[i]);
    clk_bit(last, ack);
end
endtask
endmodule // xmc_host_model

// ===== sim/xmc_mgmt_control_test.sv
// self-checking bench for the management block
`timescale 1ns/1ns
`include "xmc_defs.vh"
module xmc_mgmt_control_test;
localparam [7:0] WADDR = {`XMC_DEV_ADDR, 1'b0};
logic clk = 1'b0;
logic rst_b = 1'b0;
logic mod_desel_b = 1'b0;
logic transmitter_off = 1'b0;
logic power_down_reset = 1'b0;
logic los_detect = 1'b0;
logic fault_detect = 1'b0;
logic [3:0] reg_addr = 4'h0;
logic [7:0] reg_wdata = 8'h00;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic [7:0] mon [0:4];
logic [7:0] got [0:4];
wire scl_in, host_low, sda_out, sda_oe, interrupt_b, receive_signal_lost;
wire module_fault, module_absent, laser_enable, low_power_mode;
wire [7:0] reg_rdata;
wire sda_in = !(host_low || (sda_oe && !sda_out));
integer failures = 0;
integer checked = 0;
xmc_mgmt_control #(.DEPTH(256)) i_dut (.clk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe,
    .mod_desel_b, .transmitter_off, .power_down_reset, .los_detect, .fault_detect,
    .mon_temp(mon[0]), .mon_bias(mon[1]), .mon_txpow(mon[2]), .mon_rxpow(mon[3]),
    .mon_vcc(mon[4]), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .interrupt_b,
    .receive_signal_lost, .module_fault, .module_absent, .laser_enable, .low_power_mode);
xmc_host_model i_host (.scl(scl_in), .sda_low(host_low), .sda(sda_in));
initial
begin
    forever #5 clk = ~clk;
end
task print_verdict;
begin
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
end
endtask
task check(input logic [7:0] seen, input logic [7:0] exp);
begin
    checked++;
    if (seen !== exp)
    begin
        failures++;
        $display("wrong value at %0t: 0x%h expected 0x%h", $time, seen, exp);
    end
end
endtask
task reg_acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
begin
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
end
endtask
task wait_irq(input logic lv);
    integer n;
begin
    for (n = 0; n < 20 && interrupt_b !== lv; n++)
        @(negedge clk);
    check({7'h0, interrupt_b}, {7'h0, lv});
    if (interrupt_b !== lv)
        print_verdict;
end
endtask
task mem_wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1, input logic na);
    logic [31:0] bs;
    logic [7:0] rx;
    logic a;
    integer k;
begin
    bs = {WADDR, p, d0, d1};
    i_host.start;
    for (k = 0; k < 4; k++)
    begin
        i_host.xfer(bs[31 - 8 * k -: 8], 1'b1, rx, a);
        check({7'h0, a}, {7'h0, na});
    end
    i_host.stop;
end
endtask
task mem_rd(input logic [7:0] p, input integer n);
    logic [7:0] rx;
    logic a;
    integer k;
begin
    i_host.start;
    i_host.xfer(WADDR, 1'b1, rx, a);
    i_host.xfer(p, 1'b1, rx, a);
    i_host.start;
    i_host.xfer(WADDR | 8'h01, 1'b1, rx, a);
    for (k = 0; k < n; k++)
        i_host.xfer(8'hFF, k == n - 1, got[k], a);
    i_host.stop;
end
endtask
function automatic logic [7:0] hi_flags(input logic [7:0] t0);
    integer i;
begin
    hi_flags = 8'h00;
    for (i = 0; i < 5; i++)
        hi_flags[i] = mon[i] > (i == 0 ? t0 : 8'h00);
end
endfunction
initial
begin
    integer k;
    logic [7:0] p, d0, d1;
    k = $urandom(32'hE65EF7E1);
    for (k = 0; k < 5; k++)
        mon[k] <= 8'h01 + 8'($urandom % 253);
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (k = 0; k < 8; k++)
    begin
        @(posedge clk);
        {transmitter_off, los_detect, fault_detect} <= k[2:0];
        repeat (6) @(negedge clk);
        check({7'h0, laser_enable}, {7'h0, !k[2]});
        check({7'h0, receive_signal_lost}, {7'h0, k[1]});
        check({7'h0, module_fault}, {7'h0, k[0]});
        check({7'h0, module_absent}, 8'h00);
    end
    {transmitter_off, los_detect, fault_detect} <= 3'b000;
    $display("pin test done");
    mem_wr(8'h00, ~mon[0], ~mon[1], 1'b0);
    mem_rd(8'h00, 5);
    for (k = 0; k < 5; k++)
        check(got[k], mon[k]);
    for (k = 0; k < 4; k++)
    begin
        p = k == 0 ? 8'hFF : k == 1 ? 8'hFE : 8'h24 + 8'($urandom % 8'hDA);
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        mem_wr(p, d0, d1, 1'b0);
        mem_rd(p, 2);
        check(got[0], p == 8'hFF ? d1 : d0);
        check(got[1], d1);
    end
    mem_wr(8'h10, mon[0], 8'h00, 1'b0);
    mem_rd(8'h05, 4);
    check(got[0], hi_flags(mon[0]));
    check(got[1] | got[3], 8'h00);
    check(got[2], hi_flags(8'h00));
    $display("memory test done");
    reg_acc(1'b1, `XMC_REG_STATUS, 8'h0C);
    reg_acc(1'b0, `XMC_REG_STATUS, 8'h00);
    check(reg_rdata, 8'h03);
    reg_acc(1'b1, `XMC_REG_MASK, 8'h04);
    wait_irq(1'b1);
    los_detect <= 1'b1;
    wait_irq(1'b0);
    reg_acc(1'b1, `XMC_REG_MASK, 8'h00);
    wait_irq(1'b1);
    reg_acc(1'b1, `XMC_REG_MASK, 8'h04);
    wait_irq(1'b0);
    los_detect <= 1'b0;
    repeat (6) @(posedge clk);
    reg_acc(1'b1, `XMC_REG_STATUS, 8'h04);
    wait_irq(1'b1);
    reg_acc(1'b0, 4'hF, 8'h00);
    check(reg_rdata, 8'h00);
    reg_acc(1'b1, `XMC_REG_CTRL, 8'h03);
    reg_acc(1'b0, `XMC_REG_CTRL, 8'h00);
    check(reg_rdata, 8'h03);
    check({7'h0, module_fault}, 8'h01);
    check({7'h0, laser_enable}, 8'h00);
    reg_acc(1'b1, `XMC_REG_CTRL, 8'h00);
    reg_acc(1'b1, `XMC_REG_MASK, 8'h01);
    wait_irq(1'b0);
    $display("interrupt test done");
    @(posedge clk);
    power_down_reset <= 1'b1;
    repeat (6) @(negedge clk);
    check({7'h0, low_power_mode}, 8'h01);
    mem_rd(8'h10, 1);
    check(got[0], mon[0]);
    @(posedge clk);
    power_down_reset <= 1'b0;
    repeat (10) @(negedge clk);
    wait_irq(1'b1);
    mem_rd(8'h10, 1);
    check(got[0], 8'h00);
    $display("power-down test done");
    @(posedge clk);
    mod_desel_b <= 1'b1;
    repeat (4) @(posedge clk);
    reg_acc(1'b0, `XMC_REG_STATE, 8'h00);
    check(reg_rdata, 8'h01);
    mem_wr(8'h30, 8'h5A, 8'hA5, 1'b1);
    mod_desel_b <= 1'b0;
    repeat (4) @(posedge clk);
    mem_rd(8'h30, 1);
    check(got[0], 8'h00);
    $display("select test done");
    print_verdict;
end
endmodule // xmc_mgmt_control_test
bind xmc_mgmt_control xmc_assertions i_chk (.clk, .rst_b, .scl_in, .sda_oe, .mod_desel_b,
    .transmitter_off, .power_down_reset, .los_detect, .fault_detect, .reg_addr, .reg_wdata,
    .reg_wr, .interrupt_b, .receive_signal_lost, .module_fault, .module_absent,
    .laser_enable, .low_power_mode);
